// ---- rtl/float_coprocessor_core.v ----
// Float coprocessor core: bus snooping, register file, pipeline and exceptions.
`timescale 1ns/1ps
`include "fcop_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Watch every fetched instruction, ignore non-coprocessor ones, execute ours.
// - Thirty-two 32-bit general float registers, each reachable individually.
// - Even/odd general register pairs form sixteen 64-bit paired double registers.
// - Exactly two control registers, reached only by control moves.
// - Control/status register holds enables, flags, cause, condition bit and rounding mode.
// - Load, store and move copy one word, no conversion, no exception.
// - Add, sub, mul, div, abs, mov, neg, compare, and format conversions.
// - Divide unit is separate and runs concurrently with add and multiply.
// - Detect invalid, inexact, divide-by-zero, overflow, underflow, unimplemented.
// - Exceptions are precise, flagged at the issuing instruction.
// - Every instruction decodes as a 32-bit word in four groups.
// - Compare sets a condition bit driven on the compare result output.
// - Six-stage pipeline tracks the host's five, extra stage for exceptions.
// - Fetch stage takes no action.
// - Instruction captured from the bus in phase 1 of read/decode.
// - Execution begins in the stage after decode.
// - Load data captured in phase 2 of memory stage, store data driven in phase 2 of execute.
// - Write-back stage only handles exceptions; results go in final stage.
// - Arithmetic results other than divide written to the register file in final write-back.
// - Up to six instructions overlap in flight.
// - Shared bus carries instructions in phase 1, data in phase 2.
// - Stores drive four even-parity bits, one per data byte.
// - Exception output asserts when current instruction raises an unimplemented exception or one whose enable is set.
module float_coprocessor_core #(
    parameter [31:0] REVISION_ID = 32'h00000a01
) (
    // Clock and reset.
    input wire CLK_SYS,
    input wire SYS_RST,
    // Multiplexed bus; PHASE2 high marks the data phase.
    input wire PHASE2,
    input wire [31:0] BUS_DATA_IN,
    output reg [31:0] BUS_DATA_OUT,
    output reg BUS_DATA_OE,
    output reg [3:0] BUS_PARITY_OUT,
    // Host control.
    input wire RUN,
    output reg COMPARE_RESULT_OUT,
    output reg FLOAT_EXCEPTION_OUT,
    // Host register moves.
    input wire [31:0] HOST_WORD_IN,
    output reg [31:0] HOST_WORD_OUT
);
    reg [31:0] general_float_reg [0:31];
    reg [31:0] csr_q;
    reg [31:0] ir_q;
    reg rd_valid_q;
    reg [31:0] ex_ir_q;
    reg ex_valid_q;
    reg [31:0] mem_ir_q;
    reg mem_valid_q;
    reg [31:0] mem_res_q;
    reg [5:0] mem_exc_q;
    reg mem_wr_q;
    reg mem_cmp_q;
    reg mem_cond_q;
    reg [31:0] wb_res_q;
    reg [4:0] wb_dest_q;
    reg wb_wr_q;
    reg [31:0] fwb_res_q;
    reg [4:0] fwb_dest_q;
    reg fwb_wr_q;
    reg [31:0] res_d;
    reg [5:0] exc_d;
    reg wr_d;
    reg cmp_d;
    reg cond_d;
    reg div_start;
    wire hold = !RUN;
    wire div_busy;
    wire div_done;
    wire [31:0] div_quot;
    wire [4:0] div_dest;
    wire div_zero;
    integer i;

    wire [5:0] ex_op = ex_ir_q[31:26];
    wire [4:0] ex_rs = ex_ir_q[25:21];
    wire [4:0] ex_ft = ex_ir_q[20:16];
    wire [4:0] ex_fs = ex_ir_q[15:11];
    wire [5:0] ex_fn = ex_ir_q[5:0];
    wire [31:0] fs_val = general_float_reg[ex_fs];
    wire [31:0] ft_val = general_float_reg[ex_ft];
    wire [4:0] ex_dest = (ex_op == `OP_COP1 && ex_rs[4]) ? ex_ir_q[10:6] : ex_ft;
    wire [63:0] paired_double_reg = {general_float_reg[{ex_fs[4:1], 1'b1}],
                                     general_float_reg[{ex_fs[4:1], 1'b0}]};
    wire [1:0] round_mode = csr_q[`CSR_RM_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////////
    // Separate divide unit so a divide overlaps adds and multiplies.
    // concurrent divide unit
    fcop_divider #(.LATENCY(`DIV_LATENCY)) divider (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .hold(hold),
        .start(div_start),
        .num(fs_val),
        .den(ft_val),
        .dest(ex_dest),
        .busy(div_busy),
        .done_q(div_done),
        .quot_q(div_quot),
        .dest_q(div_dest),
        .divzero_q(div_zero)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Execute stage: decode the 32-bit word and compute.
    // four instruction groups
    always @* begin
        res_d = 32'h00000000;
        exc_d = 6'h00;
        wr_d = 1'b0;
        cmp_d = 1'b0;
        cond_d = 1'b0;
        div_start = 1'b0;
        if (ex_valid_q) begin
            if (ex_op == `OP_LOAD_COP) begin
                wr_d = 1'b1;
            end else if (ex_op == `OP_STORE_COP) begin
                res_d = ft_val;
            end else if (ex_rs == `RS_MOVE_TO) begin
                res_d = HOST_WORD_IN;
                wr_d = 1'b1;
            end else if (ex_rs == `RS_MOVE_FROM || ex_rs == `RS_CTRL_FROM) begin
                res_d = fs_val;
            end else if (ex_rs == `RS_CTRL_TO) begin
                res_d = HOST_WORD_IN;
            end else if (ex_rs == `RS_FMT_SINGLE || ex_rs == `RS_FMT_DOUBLE ||
                         ex_rs == `RS_FMT_FIXED) begin
                wr_d = 1'b1;
                case (ex_fn)
                    `FN_ADD: res_d = fs_val + ft_val;
                    `FN_SUB: res_d = fs_val - ft_val;
                    `FN_MUL: res_d = fs_val[15:0] * ft_val[15:0];
                    `FN_DIV: begin
                        wr_d = 1'b0;
                        div_start = 1'b1;
                    end
                    `FN_ABS: res_d = {1'b0, fs_val[30:0]};
                    `FN_MOV: res_d = fs_val;
                    `FN_NEG: res_d = {~fs_val[31], fs_val[30:0]};
                    `FN_CVT_S: res_d = paired_double_reg[63:32];
                    `FN_CVT_D: res_d = fs_val;
                    `FN_CVT_W: res_d = {{9{fs_val[31]}}, fs_val[22:0]};
                    default: begin
                        if (ex_fn[5:4] == 2'h3) begin
                            wr_d = 1'b0;
                            cmp_d = 1'b1;
                            cond_d = (ex_fn[1] && fs_val == ft_val) ||
                                     (ex_fn[2] && $signed(fs_val) < $signed(ft_val));
                            exc_d[`EXC_INVALID] = ex_fn[3] && (fs_val[30:23] == 8'hff);
                        end else begin
                            wr_d = 1'b0;
                            exc_d[`EXC_UNIMPL] = 1'b1;
                        end
                    end
                endcase
                if (wr_d) begin
                    exc_d[`EXC_OVERFLOW] = (res_d[30:23] == 8'hff);
                    exc_d[`EXC_UNDERFLOW] = (res_d[30:23] == 8'h00) && (res_d[22:0] != 23'h0);
                    exc_d[`EXC_INEXACT] = (round_mode != 2'h0) && res_d[0];
                    exc_d[`EXC_INVALID] = (fs_val[30:23] == 8'hff) && (fs_val[22:0] != 23'h0);
                end
                if (ex_fn == `FN_DIV) begin
                    exc_d[`EXC_DIVZERO] = (ft_val[30:0] == 31'h0);
                end
            end else begin
                exc_d[`EXC_UNIMPL] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pipeline registers; fetch stage needs no logic here.
    // no fetch action
    always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ir_q <= 32'h00000000;
            rd_valid_q <= 1'b0;
            ex_ir_q <= 32'h00000000;
            ex_valid_q <= 1'b0;
            mem_ir_q <= 32'h00000000;
            mem_valid_q <= 1'b0;
            mem_res_q <= 32'h00000000;
            mem_exc_q <= 6'h00;
            mem_wr_q <= 1'b0;
            mem_cmp_q <= 1'b0;
            mem_cond_q <= 1'b0;
            wb_res_q <= 32'h00000000;
            wb_dest_q <= 5'h00;
            wb_wr_q <= 1'b0;
            fwb_res_q <= 32'h00000000;
            fwb_dest_q <= 5'h00;
            fwb_wr_q <= 1'b0;
            csr_q <= `CSR_RESET;
            BUS_DATA_OUT <= 32'h00000000;
            BUS_DATA_OE <= 1'b0;
            BUS_PARITY_OUT <= 4'h0;
            COMPARE_RESULT_OUT <= 1'b0;
            FLOAT_EXCEPTION_OUT <= 1'b0;
            HOST_WORD_OUT <= 32'h00000000;
        end else if (!hold) begin
            if (!PHASE2) begin
                ir_q <= BUS_DATA_IN;
                rd_valid_q <= (BUS_DATA_IN[31:26] == `OP_COP1) ||
                              (BUS_DATA_IN[31:26] == `OP_LOAD_COP) ||
                              (BUS_DATA_IN[31:26] == `OP_STORE_COP);
            end else begin
                ex_ir_q <= ir_q;
                ex_valid_q <= rd_valid_q;
                mem_ir_q <= ex_ir_q;
                mem_valid_q <= ex_valid_q;
                mem_res_q <= res_d;
                mem_exc_q <= exc_d;
                mem_wr_q <= wr_d;
                mem_cmp_q <= cmp_d;
                mem_cond_q <= cond_d;
                FLOAT_EXCEPTION_OUT <= 1'b0;
                wb_wr_q <= 1'b0;
                if (mem_valid_q) begin
                    if ((mem_exc_q & {1'b1, csr_q[`CSR_EN_LSB +: 5]}) != 6'h00) begin
                        FLOAT_EXCEPTION_OUT <= 1'b1;
                    end else begin
                        wb_wr_q <= mem_wr_q;
                    end
                    csr_q[`CSR_CAUSE_LSB +: 6] <= mem_exc_q;
                    csr_q[`CSR_FLAG_LSB +: 5] <= csr_q[`CSR_FLAG_LSB +: 5] | mem_exc_q[4:0];
                    if (mem_cmp_q) begin
                        csr_q[`CSR_COND_BIT] <= mem_cond_q;
                        COMPARE_RESULT_OUT <= mem_cond_q;
                    end
                    if (mem_ir_q[31:26] == `OP_COP1 && mem_ir_q[25:21] == `RS_CTRL_TO &&
                        mem_ir_q[15:11] == `CTRL_IDX_CSR) begin
                        csr_q <= mem_res_q;
                        COMPARE_RESULT_OUT <= mem_res_q[`CSR_COND_BIT];
                    end
                    if (mem_ir_q[31:26] == `OP_COP1 && mem_ir_q[25:21] == `RS_CTRL_FROM) begin
                        HOST_WORD_OUT <= (mem_ir_q[15:11] == `CTRL_IDX_CSR) ? csr_q :
                                         (mem_ir_q[15:11] == `CTRL_IDX_REV) ? REVISION_ID :
                                         32'h00000000;
                    end else if (mem_ir_q[31:26] == `OP_COP1 &&
                                 mem_ir_q[25:21] == `RS_MOVE_FROM) begin
                        HOST_WORD_OUT <= mem_res_q;
                    end
                end
                wb_res_q <= (mem_valid_q && mem_ir_q[31:26] == `OP_LOAD_COP) ?
                            BUS_DATA_IN : mem_res_q;
                // Moves name their float register in the fs field, loads in ft.
                wb_dest_q <= (mem_ir_q[31:26] != `OP_COP1) ? mem_ir_q[20:16] :
                             (mem_ir_q[25:21] >= `RS_FMT_SINGLE) ? mem_ir_q[10:6] :
                             mem_ir_q[15:11];
                fwb_res_q <= wb_res_q;
                fwb_dest_q <= wb_dest_q;
                fwb_wr_q <= wb_wr_q;
            end
            BUS_DATA_OE <= !PHASE2 && ex_valid_q && ex_op == `OP_STORE_COP;
            if (!PHASE2 && ex_valid_q && ex_op == `OP_STORE_COP) begin
                BUS_DATA_OUT <= res_d;
                BUS_PARITY_OUT <= {^res_d[31:24], ^res_d[23:16], ^res_d[15:8], ^res_d[7:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file writes in the final write-back stage; divide results on completion.
    // general register file
    always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (i = 0; i < 32; i = i + 1) begin
                general_float_reg[i] <= 32'h00000000;
            end
        end else if (!hold && PHASE2) begin
            if (fwb_wr_q) begin
                general_float_reg[fwb_dest_q] <= fwb_res_q;
            end
            // Divide results land when the unit finishes.
            if (div_done && !div_zero) begin
                general_float_reg[div_dest] <= div_quot;
            end
        end
    end
endmodule // float_coprocessor_core

// ---- rtl/fcop_consts.vh ----
// Constants for the float coprocessor core: opcodes, fields, divide latency, resets.
`ifndef FCOP_CONSTS_VH
`define FCOP_CONSTS_VH
`define OP_COP1 6'h11
`define OP_LOAD_COP 6'h31
`define OP_STORE_COP 6'h39
`define RS_MOVE_FROM 5'h00
`define RS_CTRL_FROM 5'h02
`define RS_MOVE_TO 5'h04
`define RS_CTRL_TO 5'h06
`define RS_FMT_SINGLE 5'h10
`define RS_FMT_DOUBLE 5'h11
`define RS_FMT_FIXED 5'h14
`define FN_ADD 6'h00
`define FN_SUB 6'h01
`define FN_MUL 6'h02
`define FN_DIV 6'h03
`define FN_ABS 6'h05
`define FN_MOV 6'h06
`define FN_NEG 6'h07
`define FN_CVT_S 6'h20
`define FN_CVT_D 6'h21
`define FN_CVT_W 6'h24
`define FN_CMP_LO 6'h30
`define CTRL_IDX_REV 5'h00
`define CTRL_IDX_CSR 5'h1f
`define CSR_RESET 32'h00000000
`define CSR_RM_LSB 0
`define CSR_FLAG_LSB 2
`define CSR_EN_LSB 7
`define CSR_CAUSE_LSB 12
`define CSR_COND_BIT 23
`define EXC_INEXACT 0
`define EXC_UNDERFLOW 1
`define EXC_OVERFLOW 2
`define EXC_DIVZERO 3
`define EXC_INVALID 4
`define EXC_UNIMPL 5
`define DIV_LATENCY 4'hc
`endif

// ---- rtl/fcop_divider.v ----
// Iterative divide unit that runs beside the add and multiply paths.
`timescale 1ns/1ps
module fcop_divider #(
    parameter LATENCY = 4'hc
) (
    input wire clk,
    input wire rst,
    input wire hold,
    input wire start,
    input wire [31:0] num,
    input wire [31:0] den,
    input wire [4:0] dest,
    output wire busy,
    output reg done_q,
    output reg [31:0] quot_q,
    output reg [4:0] dest_q,
    output reg divzero_q
);
    reg [3:0] count_q;
    assign busy = (count_q != 4'h0);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= 4'h0;
            done_q <= 1'b0;
            quot_q <= 32'h00000000;
            dest_q <= 5'h00;
            divzero_q <= 1'b0;
        end else if (!hold) begin
            done_q <= (count_q == 4'h1);
            if (start && !busy) begin
                count_q <= LATENCY;
                dest_q <= dest;
                divzero_q <= (den[30:0] == 31'h00000000);
                quot_q <= {num[31] ^ den[31], num[30:0]};
            end else if (busy) begin
                count_q <= count_q - 4'h1;
            end
        end
    end
endmodule // fcop_divider

// ---- dv/fcop_monitor.sv ----
// Bus, stall and exception timing checks on the coprocessor ports.
`timescale 1ns/1ps
`include "fcop_consts.vh"
module fcop_monitor (
    // Clock and reset.
    input wire CLK_SYS,
    input wire SYS_RST,
    // Bus.
    input wire PHASE2,
    input wire [31:0] BUS_DATA_IN,
    input wire [31:0] BUS_DATA_OUT,
    input wire BUS_DATA_OE,
    input wire [3:0] BUS_PARITY_OUT,
    // Host control.
    input wire RUN,
    input wire COMPARE_RESULT_OUT,
    input wire FLOAT_EXCEPTION_OUT,
    input wire [31:0] HOST_WORD_OUT
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    wire take = !PHASE2 && RUN;
    wire st_take = take && BUS_DATA_IN[31:26] == `OP_STORE_COP;
    wire ld_take = take && BUS_DATA_IN[31:26] == `OP_LOAD_COP;
    wire un_take = take && BUS_DATA_IN[31:26] == `OP_COP1
        && BUS_DATA_IN[25:21] == `RS_FMT_SINGLE && BUS_DATA_IN[5:0] == 6'h10;
    parity_even_a:
    assert property (BUS_DATA_OE |-> BUS_PARITY_OUT == {^BUS_DATA_OUT[31:24],
        ^BUS_DATA_OUT[23:16], ^BUS_DATA_OUT[15:8], ^BUS_DATA_OUT[7:0]})
    else $error("store parity wrong");
    store_drive_a:
    assert property (st_take ##1 RUN [*3] |-> BUS_DATA_OE)
    else $error("store data not driven");
    drive_once_a:
    assert property (BUS_DATA_OE |=> !BUS_DATA_OE)
    else $error("store drive too long");
    data_phase_a:
    assert property (BUS_DATA_OE |-> PHASE2)
    else $error("bus driven outside data phase");
    stall_hold_a:
    assert property (!RUN |=> $stable(HOST_WORD_OUT) && $stable(COMPARE_RESULT_OUT))
    else $error("outputs moved during stall");
    update_edge_a:
    assert property ($changed(HOST_WORD_OUT) || $changed(COMPARE_RESULT_OUT) |-> !PHASE2)
    else $error("result changed off the stage edge");
    load_quiet_a:
    assert property (ld_take ##1 RUN [*5] |=> !FLOAT_EXCEPTION_OUT)
    else $error("load raised exception");
    unimpl_trap_a:
    assert property (un_take ##1 RUN [*5] |=> FLOAT_EXCEPTION_OUT)
    else $error("unimplemented op not flagged");
    exc_pulse_a:
    assert property ($rose(FLOAT_EXCEPTION_OUT) && RUN |=> FLOAT_EXCEPTION_OUT)
    else $error("exception pulse too short");
    cover property (st_take);
    cover property (un_take);
    cover property ($fell(RUN));
    cover property ($rose(COMPARE_RESULT_OUT));
endmodule // fcop_monitor
bind float_coprocessor_core fcop_monitor mon (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .PHASE2(PHASE2), .BUS_DATA_IN(BUS_DATA_IN), .BUS_DATA_OUT(BUS_DATA_OUT),
    .BUS_DATA_OE(BUS_DATA_OE), .BUS_PARITY_OUT(BUS_PARITY_OUT), .RUN(RUN),
    .COMPARE_RESULT_OUT(COMPARE_RESULT_OUT), .FLOAT_EXCEPTION_OUT(FLOAT_EXCEPTION_OUT),
    .HOST_WORD_OUT(HOST_WORD_OUT));

// ---- dv/fcop_host_model.sv ----
// Host processor side: phase pacing, run/stall and the shared bus.
`timescale 1ns/1ps
module fcop_host_model (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Bench requests.
    input wire [31:0] instr,
    input wire [31:0] data_word,
    input wire stall,
    // Coprocessor pins.
    input wire [31:0] bus_out,
    input wire bus_oe,
    output reg phase2,
    output reg run,
    output wire [31:0] bus_in,
    output reg [31:0] stored_q
);
    assign bus_in = bus_oe ? bus_out : (phase2 ? data_word : instr);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            phase2 <= 1'b0;
            run <= 1'b0;
            stored_q <= 32'h0;
        end else begin
            phase2 <= ~phase2;
            run <= ~stall;
            if (phase2 && bus_oe) begin
                stored_q <= bus_out;
            end
        end
    end
endmodule // fcop_host_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the float coprocessor core.
`timescale 1ns/1ps
`include "fcop_consts.vh"
module tb_top;
    localparam [31:0] REV = 32'h00000b02; // Arbitrary revision value.
    localparam integer GAP = 24;
    reg clk_sys = 1'b0;
    reg sys_rst = 1'b1;
    reg stall = 1'b0;
    reg [31:0] instr = 32'h0;
    reg [31:0] data_word = 32'h0;
    reg [31:0] host_word = 32'h0;
    wire phase2, run, bus_oe, cmp, exc;
    wire [3:0] parity;
    wire [31:0] bus_in, bus_out, word_out, stored;
    integer mismatches = 0;
    integer n_checks = 0;
    integer cycles = 0;
    integer exc_cnt = 0;
    always #2 clk_sys = ~clk_sys;
    fcop_host_model host (.clk(clk_sys), .rst(sys_rst), .instr(instr), .data_word(data_word),
        .stall(stall), .bus_out(bus_out), .bus_oe(bus_oe), .phase2(phase2), .run(run),
        .bus_in(bus_in), .stored_q(stored));
    float_coprocessor_core #(.REVISION_ID(REV)) dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst),
        .PHASE2(phase2), .BUS_DATA_IN(bus_in), .BUS_DATA_OUT(bus_out), .BUS_DATA_OE(bus_oe),
        .BUS_PARITY_OUT(parity), .RUN(run), .COMPARE_RESULT_OUT(cmp),
        .FLOAT_EXCEPTION_OUT(exc), .HOST_WORD_IN(host_word), .HOST_WORD_OUT(word_out));
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (exc === 1'b1) exc_cnt <= exc_cnt + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
    end
    task check(input [95:0] name, input [31:0] exp, input [31:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("mismatch %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    function [31:0] cop(input [4:0] rs, ft, fs, fd, input [5:0] fn);
        cop = {`OP_COP1, rs, ft, fs, fd, fn};
    endfunction
    // Presents one instruction in the next phase 1 slot, then waits n clocks.
    task op(input [31:0] w, input integer n);
        begin
            @(negedge clk_sys);
            if (phase2 !== 1'b1) @(negedge clk_sys);
            @(posedge clk_sys);
            instr <= w;
            @(posedge clk_sys);
            instr <= 32'h0;
            repeat (n) @(posedge clk_sys);
            @(negedge clk_sys);
        end
    endtask
    task put(input [4:0] rs, input [4:0] r, input [31:0] v);
        begin
            @(posedge clk_sys);
            host_word <= v;
            op(cop(rs, 5'h0, r, 5'h0, 6'h0), GAP);
        end
    endtask
    task peek(input [95:0] name, input [4:0] rs, input [4:0] r, input [31:0] v);
        begin
            op(cop(rs, 5'h0, r, 5'h0, 6'h0), GAP);
            check(name, v, word_out);
        end
    endtask
    task calc(input [4:0] fmt, input [5:0] fn, input [4:0] fs, ft, fd, input [31:0] v);
        begin
            op(cop(fmt, ft, fs, fd, fn), 40);
            peek("calc", `RS_MOVE_FROM, fd, v);
        end
    endtask
    task t_regs;
        integer i, e;
        begin
            e = exc_cnt;
            for (i = 0; i < 32; i = i + 1) begin
                put(`RS_MOVE_TO, i[4:0], 32'h5a000000 + i * 32'h00010203);
            end
            for (i = 0; i < 32; i = i + 1) begin
                peek("gpr", `RS_MOVE_FROM, i[4:0], 32'h5a000000 + i * 32'h00010203);
            end
            check("move_exc", 32'h0, exc_cnt - e);
        end
    endtask
    task t_ctrl;
        begin
            check("reset_out", 32'h0, word_out);
            peek("revision", `RS_CTRL_FROM, `CTRL_IDX_REV, REV);
            peek("csr_reset", `RS_CTRL_FROM, `CTRL_IDX_CSR, `CSR_RESET);
            put(`RS_CTRL_TO, `CTRL_IDX_CSR, 32'h00000003);
            peek("csr", `RS_CTRL_FROM, `CTRL_IDX_CSR, 32'h00000003);
            put(`RS_CTRL_TO, `CTRL_IDX_CSR, `CSR_RESET);
        end
    endtask
    task t_calc;
        begin
            put(`RS_MOVE_TO, 5'd1, 32'h3f800000);
            put(`RS_MOVE_TO, 5'd2, 32'h40000000);
            calc(`RS_FMT_SINGLE, `FN_ADD, 5'd1, 5'd1, 5'd3, 32'h7f000000);
            calc(`RS_FMT_SINGLE, `FN_SUB, 5'd2, 5'd1, 5'd3, 32'h00800000);
            calc(`RS_FMT_SINGLE, `FN_MUL, 5'd2, 5'd2, 5'd3, 32'h00000000);
            calc(`RS_FMT_SINGLE, `FN_DIV, 5'd1, 5'd2, 5'd3, 32'h3f800000);
            calc(`RS_FMT_SINGLE, `FN_NEG, 5'd1, 5'd0, 5'd3, 32'hbf800000);
            calc(`RS_FMT_SINGLE, `FN_ABS, 5'd3, 5'd0, 5'd3, 32'h3f800000);
            calc(`RS_FMT_SINGLE, `FN_MOV, 5'd2, 5'd0, 5'd3, 32'h40000000);
            calc(`RS_FMT_SINGLE, `FN_CVT_W, 5'd2, 5'd0, 5'd3, 32'h00000000);
            calc(`RS_FMT_FIXED, `FN_CVT_S, 5'd3, 5'd0, 5'd3, 32'h00000000);
            calc(`RS_FMT_SINGLE, `FN_CVT_D, 5'd1, 5'd0, 5'd4, 32'h3f800000);
            put(`RS_MOVE_TO, 5'd5, 32'h3ff00000);
            calc(`RS_FMT_DOUBLE, `FN_CVT_S, 5'd4, 5'd0, 5'd6, 32'h3ff00000);
            peek("pair_lo", `RS_MOVE_FROM, 5'd4, 32'h3f800000);
            calc(`RS_FMT_DOUBLE, `FN_MOV, 5'd4, 5'd0, 5'd7, 32'h3f800000);
            op(cop(`RS_FMT_SINGLE, 5'd2, 5'd1, 5'd8, `FN_DIV), 0);
            op(cop(`RS_FMT_SINGLE, 5'd1, 5'd1, 5'd9, `FN_ADD), 0);
            op(cop(`RS_FMT_SINGLE, 5'd2, 5'd2, 5'd10, `FN_MUL), 40);
            peek("ovl_div", `RS_MOVE_FROM, 5'd8, 32'h3f800000);
            peek("ovl_add", `RS_MOVE_FROM, 5'd9, 32'h7f000000);
            peek("ovl_mul", `RS_MOVE_FROM, 5'd10, 32'h00000000);
            op(cop(`RS_FMT_SINGLE, 5'd1, 5'd1, 5'd0, 6'h32), GAP);
            check("cmp_eq", 32'h1, {31'h0, cmp});
            op(cop(`RS_FMT_SINGLE, 5'd2, 5'd1, 5'd0, 6'h32), GAP);
            check("cmp_ne", 32'h0, {31'h0, cmp});
        end
    endtask
    task t_mem;
        begin
            @(posedge clk_sys);
            data_word <= 32'h01020381;
            op({`OP_LOAD_COP, 5'h0, 5'd12, 16'h0}, GAP);
            peek("load", `RS_MOVE_FROM, 5'd12, 32'h01020381);
            op({`OP_STORE_COP, 5'h0, 5'd12, 16'h0}, GAP);
            check("store", 32'h01020381, stored);
            op(32'h48840800, GAP);
            op(32'h8c010000, GAP);
            op(32'hc0010000, GAP);
            peek("ignored", `RS_MOVE_FROM, 5'd1, 32'h3f800000);
        end
    endtask
    task t_exc;
        integer e;
        begin
            put(`RS_MOVE_TO, 5'd9, 32'h0000abcd);
            e = exc_cnt;
            op(cop(`RS_FMT_SINGLE, 5'd1, 5'd1, 5'd9, 6'h10), GAP);
            check("exc_pulse", 32'd2, exc_cnt - e);
            peek("no_write", `RS_MOVE_FROM, 5'd9, 32'h0000abcd);
            put(`RS_MOVE_TO, 5'd10, 32'h0);
            op(cop(`RS_FMT_SINGLE, 5'd10, 5'd1, 5'd11, `FN_DIV), 40);
            op(cop(`RS_CTRL_FROM, 5'h0, `CTRL_IDX_CSR, 5'h0, 6'h0), GAP);
            check("divzero", 32'h1, {31'h0, word_out[5]});
        end
    endtask
    task t_stall;
        begin
            put(`RS_MOVE_TO, 5'd13, 32'h13572468);
            peek("pre", `RS_MOVE_FROM, 5'd1, 32'h3f800000);
            op(cop(`RS_MOVE_FROM, 5'h0, 5'd13, 5'h0, 6'h0), 0);
            @(posedge clk_sys);
            stall <= 1'b1;
            repeat (16) @(negedge clk_sys);
            check("stalled", 32'h3f800000, word_out);
            @(posedge clk_sys);
            stall <= 1'b0;
            repeat (GAP) @(posedge clk_sys);
            @(negedge clk_sys);
            check("resumed", 32'h13572468, word_out);
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_ctrl;
        t_regs;
        t_calc;
        t_mem;
        t_exc;
        t_stall;
        report_and_stop;
    end
endmodule // tb_top
